// ===== hdl/pcs_pkg.sv
/*
 * Package for the port 4 chip-select strobe block: register offsets, field
 * positions, reset values and mode encodings.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package pcs_pkg;

    // Register indices (byte address = index * 4, printed offsets are not word aligned)
    localparam logic [7:0] IDX_STROBE_POLARITY = 8'hae;
    localparam logic [7:0] IDX_LOW_PINS_CFG = 8'hc2;
    localparam logic [7:0] IDX_HIGH_PINS_CFG = 8'hc3;
    localparam logic [7:0] IDX_PORT4_DATA = 8'hd8;
    // Pin 0 base bytes have fixed indices; pins 1..3 use IDX_BASE_ADDR_FIRST + 2*pin + (0 low, 1 high)
    localparam logic [7:0] IDX_PIN0_BASE_LOW = 8'h84;
    localparam logic [7:0] IDX_PIN0_BASE_HIGH = 8'h85;
    localparam logic [7:0] IDX_BASE_ADDR_FIRST = 8'he0;
    localparam int ADDR_WORD_SHIFT = 2;

    // Field positions
    localparam int CFG_FUN_HI_POS = 6;
    localparam int CFG_CMP_HI_POS = 4;
    localparam int CFG_FUN_LO_POS = 2;
    localparam int CFG_CMP_LO_POS = 0;
    localparam int POL_INV_POS = 4;

    // Reset values
    localparam logic [7:0] RST_POLARITY = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_PORT4_DATA = 8'hff;
    localparam logic [7:0] RST_BASE_ADDR = 8'h00;

    // Pin function
    typedef enum logic [1:0] {
        PCS_FUN_GPIO = 2'h0,
        PCS_FUN_READ = 2'h1,
        PCS_FUN_WRITE = 2'h2,
        PCS_FUN_RDWR = 2'h3
    } pcs_fun_t;

    // Address compare length
    typedef enum logic [1:0] {
        PCS_CMP_FULL = 2'h0,
        PCS_CMP_A15_A1 = 2'h1,
        PCS_CMP_A15_A2 = 2'h2,
        PCS_CMP_A15_A8 = 2'h3
    } pcs_cmp_t;

endpackage : pcs_pkg

// ===== hdl/pcs_sync2.sv
/*
 * Two flip-flop synchroniser for a bus of pin levels.
 * Assumes the inputs are asynchronous to core_clk_i.
 */
module pcs_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule : pcs_sync2

// ===== hdl/pcs_port4.sv
/*
 * Port 4 chip-select strobe block: four pins driven either from the port
 * data register or as address-decoded read, write or read/write strobes.
 * Assumes an APB master on core_clk_i and the external bus strobes
 * (active-low read and write, 16-bit address) from the CPU on the same clock.
 */
// The APB slave port is this design's own decision.
// Overview of operation
// - Low-pin config bits 7:6 select pin 1 function, coded like pin 3.
// - Low-pin config bits 5:4 set pin 1 compare length, coded like pin 3.
// - Low-pin config bits 3:2 select pin 0 function, coded like pin 3.
// - Low-pin config bits 1:0 set pin 0 compare length, coded like pin 3.
// - Polarity bits 7..4 pick strobe polarity of pins 3..0; one is high.
// - Each pin has a 16-bit base address from high and low byte registers.
// - Port data bits 3..0 drive pins 3..0 in general-purpose mode.
// - Strobes default active low; a set polarity bit makes them active high.
// - Compare length 10 ignores A1 and A0, four addresses match.
// - Write matching a write-strobe pin's masked base asserts its strobe.
// - Function codes: 00 I/O, 01 read, 10 write, 11 read/write strobe.
// - Compare codes: 00 all bits, 01 A15-A1, 10 A15-A2, 11 A15-A8.
// - Strobes follow the external read and write strobes of the access.
module pcs_port4 (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // External data bus of the CPU
    input wire logic [15:0] ext_addr_i,
    input wire logic ext_rd_n_i,
    input wire logic ext_wr_n_i,
    // Port 4 pins
    input wire logic [3:0] port4_pin_i,
    output logic [3:0] port4_pin_o,
    output logic [3:0] port4_pin_oe_o
);

    import pcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] cmp_mask(input logic [1:0] len);
        case (pcs_cmp_t'(len))
            PCS_CMP_FULL: cmp_mask = 16'hffff;
            PCS_CMP_A15_A1: cmp_mask = 16'hfffe;
            PCS_CMP_A15_A2: cmp_mask = 16'hfffc;
            default: cmp_mask = 16'hff00;
        endcase
    endfunction : cmp_mask

    function automatic logic word_hit(input logic [11:0] addr, input logic [7:0] idx);
        word_hit = (addr[11:ADDR_WORD_SHIFT] == {2'h0, idx});
    endfunction : word_hit

    // Base byte number 0..7 to register index; pin 0 sits apart from the rest
    function automatic logic [7:0] base_idx(input int i);
        if (i == 0)
        begin
            base_idx = IDX_PIN0_BASE_LOW;
        end
        else if (i == 1)
        begin
            base_idx = IDX_PIN0_BASE_HIGH;
        end
        else
        begin
            base_idx = IDX_BASE_ADDR_FIRST + 8'(i);
        end
    endfunction : base_idx

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] strobe_polarity;
    logic [7:0] low_pins_strobe_config;
    logic [7:0] high_pins_strobe_config;
    logic [7:0] port4_data;
    logic [7:0] base_addr_byte [8];

    logic apb_write;
    logic apb_read;
    logic [3:0] pin_level;

    assign apb_write = psel_i && penable_i && pwrite_i;
    assign apb_read = psel_i && penable_i && !pwrite_i;

    // Zero-wait slave; every access completes in its first access cycle
    assign pready_o = 1'b1;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            strobe_polarity <= RST_POLARITY;
            low_pins_strobe_config <= RST_CFG;
            high_pins_strobe_config <= RST_CFG;
            port4_data <= RST_PORT4_DATA;
        end
        else if (apb_write)
        begin
            if (word_hit(paddr_i, IDX_STROBE_POLARITY))
            begin
                // Low nibble reserved, reads back zero
                strobe_polarity <= {pwdata_i[7:4], 4'h0};
            end
            else if (word_hit(paddr_i, IDX_LOW_PINS_CFG))
            begin
                low_pins_strobe_config <= pwdata_i[7:0];
            end
            else if (word_hit(paddr_i, IDX_HIGH_PINS_CFG))
            begin
                high_pins_strobe_config <= pwdata_i[7:0];
            end
            else if (word_hit(paddr_i, IDX_PORT4_DATA))
            begin
                port4_data <= pwdata_i[7:0];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                base_addr_byte[i] <= RST_BASE_ADDR;
            end
        end
        else if (apb_write)
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (word_hit(paddr_i, base_idx(i)))
                begin
                    base_addr_byte[i] <= pwdata_i[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic base_hit;
    logic [2:0] base_num;

    // Base bytes are not one contiguous run, so search all eight
    always_comb
    begin
        base_hit = 1'b0;
        base_num = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (word_hit(paddr_i, base_idx(i)))
            begin
                base_hit = 1'b1;
                base_num = 3'(i);
            end
        end
    end

    logic [7:0] next_rdata;
    logic next_slverr;

    always_comb
    begin
        next_rdata = 8'h00;
        next_slverr = 1'b0;
        if (word_hit(paddr_i, IDX_STROBE_POLARITY))
        begin
            next_rdata = strobe_polarity;
        end
        else if (word_hit(paddr_i, IDX_LOW_PINS_CFG))
        begin
            next_rdata = low_pins_strobe_config;
        end
        else if (word_hit(paddr_i, IDX_HIGH_PINS_CFG))
        begin
            next_rdata = high_pins_strobe_config;
        end
        else if (word_hit(paddr_i, IDX_PORT4_DATA))
        begin
            // Upper bits read latch, lower bits show the pin levels
            next_rdata = {port4_data[7:4], pin_level};
        end
        else if (base_hit)
        begin
            next_rdata = base_addr_byte[base_num];
        end
        else
        begin
            next_slverr = 1'b1;
        end
    end

    // Read data is combinational off the held address, driven only in a read's access phase, zero otherwise
    assign prdata_o = apb_read ? {24'h0, next_rdata} : 32'h0;
    assign pslverr_o = psel_i && penable_i && next_slverr;

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs

    pcs_sync2 #(
        .WIDTH(4)
    ) u_pin_sync (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(port4_pin_i),
        .sync_o(pin_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strobe decode

    logic [1:0] pin_fun [4];
    logic [1:0] pin_cmp [4];
    logic [3:0] strobe_active;
    logic [3:0] addr_hit;
    logic [15:0] pin_mask [4];
    logic [3:0] next_pin;
    logic [3:0] next_oe;

    always_comb
    begin
        pin_fun[3] = high_pins_strobe_config[CFG_FUN_HI_POS +: 2];
        pin_cmp[3] = high_pins_strobe_config[CFG_CMP_HI_POS +: 2];
        pin_fun[2] = high_pins_strobe_config[CFG_FUN_LO_POS +: 2];
        pin_cmp[2] = high_pins_strobe_config[CFG_CMP_LO_POS +: 2];
        pin_fun[1] = low_pins_strobe_config[CFG_FUN_HI_POS +: 2];
        pin_cmp[1] = low_pins_strobe_config[CFG_CMP_HI_POS +: 2];
        pin_fun[0] = low_pins_strobe_config[CFG_FUN_LO_POS +: 2];
        pin_cmp[0] = low_pins_strobe_config[CFG_CMP_LO_POS +: 2];
    end

    // Masked compare of the bus address against each pin's base
    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            pin_mask[p] = cmp_mask(pin_cmp[p]);
            addr_hit[p] = (ext_addr_i & pin_mask[p])
                          == ({base_addr_byte[2 * p + 1], base_addr_byte[2 * p]} & pin_mask[p]);
        end
    end

    always_comb
    begin
        for (int p = 0; p < 4; p++)
        begin
            case (pcs_fun_t'(pin_fun[p]))
                PCS_FUN_READ: strobe_active[p] = addr_hit[p] && !ext_rd_n_i;
                PCS_FUN_WRITE: strobe_active[p] = addr_hit[p] && !ext_wr_n_i;
                PCS_FUN_RDWR: strobe_active[p] = addr_hit[p] && (!ext_rd_n_i || !ext_wr_n_i);
                default: strobe_active[p] = 1'b0;
            endcase
            if (pin_fun[p] == PCS_FUN_GPIO)
            begin
                // Quasi-bidirectional: drive only a low, a one lets the pin float high
                next_pin[p] = port4_data[p];
                next_oe[p] = !port4_data[p];
            end
            else
            begin
                next_pin[p] = strobe_active[p] ~^ strobe_polarity[POL_INV_POS + p];
                next_pin[p] = !next_pin[p] ? 1'b0 : 1'b1;
                next_oe[p] = 1'b1;
            end
        end
    end

    // Registered pins: strobes lag the bus strobes by one clock, a trade for clean outputs
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            port4_pin_o <= 4'hf;
            port4_pin_oe_o <= 4'h0;
        end
        else
        begin
            port4_pin_o <= next_pin;
            port4_pin_oe_o <= next_oe;
        end
    end

endmodule : pcs_port4

// ===== dv/pcs_port4_props.sv
/* Checker for the port 4 strobe block.
   Sees only the top ports; it shadows all registers but the high-pin config from APB writes. */
module pcs_port4_props (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [15:0] ext_addr_i,
    input wire logic ext_rd_n_i,
    input wire logic ext_wr_n_i,
    input wire logic [3:0] port4_pin_o,
    input wire logic [3:0] port4_pin_oe_o
);
    import pcs_pkg::*;
    logic [7:0] pol, cfg, dat;
    logic [7:0] base [8];
    logic [1:0] exp_pin;
    wire acc = psel_i && penable_i;
    wire rd = acc && !pwrite_i;
    wire [9:0] idx = paddr_i[11:2];
    wire [7:0] ix = idx[7:0];
    wire in_run = ix[7:3] == IDX_BASE_ADDR_FIRST[7:3];
    wire is_base = ix == IDX_PIN0_BASE_LOW || ix == IDX_PIN0_BASE_HIGH || in_run && ix[2:1] != 2'h0;
    wire [2:0] bnum = in_run ? ix[2:0] : {2'h0, ix == IDX_PIN0_BASE_HIGH};
    wire mapped = idx[9:8] == 2'h0 && (ix == IDX_STROBE_POLARITY || ix == IDX_LOW_PINS_CFG
        || ix == IDX_HIGH_PINS_CFG || ix == IDX_PORT4_DATA || is_base);
    wire [1:0] exp_oe = {cfg[7:6] != 2'h0 || !dat[1], cfg[3:2] != 2'h0 || !dat[0]};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pol <= RST_POLARITY;
            cfg <= RST_CFG;
            dat <= RST_PORT4_DATA;
            base <= '{default: RST_BASE_ADDR};
        end
        else if (acc && pwrite_i && mapped)
        begin
            if (ix == IDX_STROBE_POLARITY) pol <= pwdata_i[7:0];
            if (ix == IDX_LOW_PINS_CFG) cfg <= pwdata_i[7:0];
            if (ix == IDX_PORT4_DATA) dat <= pwdata_i[7:0];
            if (is_base) base[bnum] <= pwdata_i[7:0];
        end
    end
    // Level the pin must show one edge later
    function automatic logic pin_exp(input int k);
        logic [1:0] fn;
        logic [1:0] cm;
        logic [15:0] mask;
        logic act;
        fn = cfg[4*k+2 +: 2];
        cm = cfg[4*k +: 2];
        mask = cm == 2'h0 ? 16'hffff : cm == 2'h1 ? 16'hfffe : cm == 2'h2 ? 16'hfffc : 16'hff00;
        act = (((ext_addr_i ^ {base[2*k+1], base[2*k]}) & mask) == 16'h0)
            && (fn[0] && !ext_rd_n_i || fn[1] && !ext_wr_n_i);
        return fn == PCS_FUN_GPIO ? dat[k] : act == pol[4+k];
    endfunction : pin_exp
    always_comb
    begin
        exp_pin[0] = pin_exp(0);
        exp_pin[1] = pin_exp(1);
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_pin0;
        1'b1 |=> port4_pin_o[0] == $past(exp_pin[0]);
    endproperty
    a_pin0: assert property (p_pin0) else $error("pin 0 level wrong");
    property p_pin1;
        1'b1 |=> port4_pin_o[1] == $past(exp_pin[1]);
    endproperty
    a_pin1: assert property (p_pin1) else $error("pin 1 level wrong");
    property p_oe;
        1'b1 |=> port4_pin_oe_o[1:0] == $past(exp_oe);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");
    property p_exit;
        $past(arst_n_i) == 1'b0 |-> port4_pin_o == 4'hf && port4_pin_oe_o == 4'h0;
    endproperty
    a_exit: assert property (p_exit) else $error("pins wrong after reset");
    property p_pol;
        rd && mapped && ix == IDX_STROBE_POLARITY |-> prdata_o == {24'h0, pol[7:4], 4'h0};
    endproperty
    a_pol: assert property (p_pol) else $error("polarity read wrong");
    property p_cfg;
        rd && idx == {2'h0, IDX_LOW_PINS_CFG} |-> prdata_o == {24'h0, cfg};
    endproperty
    a_cfg: assert property (p_cfg) else $error("config read wrong");
    property p_base;
        rd && mapped && is_base |-> prdata_o[7:0] == base[bnum];
    endproperty
    a_base: assert property (p_base) else $error("base read wrong");
    property p_unmapped;
        acc |-> pready_o && pslverr_o == !mapped && (mapped || prdata_o == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access wrong");
    c_wr: cover property (cfg[3:2] == 2'h2 && !ext_wr_n_i ##1 port4_pin_o[0] == pol[4]);
    c_rd: cover property (cfg[7:6] == 2'h1 && !ext_rd_n_i);
    c_err: cover property (acc && pslverr_o);
endmodule : pcs_port4_props

bind pcs_port4 pcs_port4_props u_pcs_port4_props (.*);

// ===== dv/pcs_pin_model.sv
/* Board at port 4: pull-ups on every pin.
   Assumes the block drives a pin only while its enable is high. */
module pcs_pin_model (
    input wire logic [3:0] pin_o_i,
    input wire logic [3:0] pin_oe_i,
    output logic [3:0] pin_level_o
);
    // A released pin floats up, never keeps the last driven level
    assign pin_level_o = (pin_o_i & pin_oe_i) | ~pin_oe_i;
endmodule : pcs_pin_model

// ===== dv/port4_chip_select_strobes_tb.sv
/* Testbench for the port 4 strobe block: APB register tests and strobe decode.
   Assumes zero to 15 APB wait states and a one-cycle pin lag. */
module port4_chip_select_strobes_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcs_pkg::*;
    logic core_clk_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [15:0] ext_addr_i = 16'h0;
    logic ext_rd_n_i = 1'b1, ext_wr_n_i = 1'b1;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o;
    logic [3:0] port4_pin_i, port4_pin_o, port4_pin_oe_o;
    logic [15:0] addrs [6] = '{16'h1234, 16'h1235, 16'h1237, 16'h1238, 16'h12ff, 16'h1334};
    int n_fail = 0;
    int checks = 0;
    pcs_port4 u_pcs_port4 (.*);
    pcs_pin_model u_pcs_pin_model (.pin_o_i(port4_pin_o), .pin_oe_i(port4_pin_oe_o), .pin_level_o(port4_pin_i));
    always #4 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    function automatic logic [7:0] bidx(input int i);
        return i == 0 ? IDX_PIN0_BASE_LOW : i == 1 ? IDX_PIN0_BASE_HIGH : IDX_BASE_ADDR_FIRST + 8'(i);
    endfunction : bidx
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [31:0] res);
        int n;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {2'h0, idx, 2'h0};
        pwdata_i <= {24'h0, wd};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge core_clk_i);
            if (pready_o === 1'b1)
                break;
        end
        // Bit 31 carries the error flag; the data bytes never reach it
        res = {pslverr_o, prdata_o[30:0]};
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n == 16)
        begin
            n_fail++;
            stop_test();
        end
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] res;
        apb(idx, 1'b1, wd, res);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] res;
        apb(idx, 1'b0, 8'h00, res);
        chk(res, exp);
    endtask : rd
    task automatic ext(input int k, input logic [15:0] a, input logic r_n, input logic w_n, input logic act, input logic pol);
        @(posedge core_clk_i);
        ext_addr_i <= a;
        ext_rd_n_i <= r_n;
        ext_wr_n_i <= w_n;
        repeat (2) @(posedge core_clk_i);
        chk({port4_pin_o[k], port4_pin_oe_o[k]}, {act == pol, 1'b1});
        ext_addr_i <= ~a;
        ext_rd_n_i <= 1'b1;
        ext_wr_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        chk({port4_pin_o[k], port4_pin_oe_o[k]}, {!pol, 1'b1});
    endtask : ext
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge core_clk_i);
        n_fail++;
        stop_test();
    end
    initial
    begin
        logic [15:0] m;
        logic p;
        repeat (3) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        chk({port4_pin_o, port4_pin_oe_o}, 32'hf0);
        rd(IDX_STROBE_POLARITY, 32'h0);
        rd(IDX_PORT4_DATA, 32'hff);
        wr(IDX_STROBE_POLARITY, 8'hff);
        rd(IDX_STROBE_POLARITY, 32'hf0);
        wr(IDX_LOW_PINS_CFG, 8'ha5);
        rd(IDX_LOW_PINS_CFG, 32'ha5);
        wr(IDX_HIGH_PINS_CFG, 8'h5a);
        rd(IDX_HIGH_PINS_CFG, 32'h5a);
        for (int i = 0; i < 8; i++) wr(bidx(i), {4'(i), 4'(~i)});
        for (int i = 0; i < 8; i++) rd(bidx(i), {24'h0, 4'(i), 4'(~i)});
        wr(8'h10, 8'h55);
        rd(8'h10, 32'h80000000);
        $display("Test registers done");
        wr(IDX_LOW_PINS_CFG, 8'h00);
        wr(IDX_HIGH_PINS_CFG, 8'h00);
        wr(IDX_PORT4_DATA, 8'hfa);
        repeat (2) @(posedge core_clk_i);
        chk({port4_pin_o, port4_pin_oe_o}, 32'ha5);
        rd(IDX_PORT4_DATA, 32'hfa);
        wr(IDX_PORT4_DATA, 8'hff);
        $display("Test port data done");
        for (int i = 0; i < 8; i++) wr(bidx(i), i[0] ? 8'h12 : 8'h34);
        for (int k = 0; k < 4; k++)
            for (int f = 1; f < 4; f++)
                for (int c = 0; c < 4; c++)
                begin
                    p = f[1] ^ c[0];
                    m = c == 0 ? 16'hffff : c == 1 ? 16'hfffe : c == 2 ? 16'hfffc : 16'hff00;
                    wr(IDX_STROBE_POLARITY, {p, p, p, p, 4'h0});
                    wr(k < 2 ? IDX_LOW_PINS_CFG : IDX_HIGH_PINS_CFG, 8'({2'(f), 2'(c)}) << (4 * (k % 2)));
                    foreach (addrs[j])
                    begin
                        ext(k, addrs[j], 1'b0, 1'b1, ((addrs[j] ^ 16'h1234) & m) == 16'h0 && f[0], p);
                        ext(k, addrs[j], 1'b1, 1'b0, ((addrs[j] ^ 16'h1234) & m) == 16'h0 && f[1], p);
                    end
                end
        $display("Test strobes done");
        arst_n_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        chk({port4_pin_o, port4_pin_oe_o}, 32'hf0);
        rd(IDX_STROBE_POLARITY, 32'h0);
        rd(IDX_LOW_PINS_CFG, 32'h0);
        rd(bidx(0), 32'h0);
        $display("Test mid-run reset done");
        stop_test();
    end
endmodule : port4_chip_select_strobes_tb
